// ### core/interrupt_mask_and_ip_regs.sv
// Summary of operation
// - The level mask holds eight read/write bits, bit n for level n, 0 masks and 1 unmasks.
// - A level whose mask bit is 0 never reaches the CPU, whatever drives its request.
// - The pointer high byte is a read/write byte holding pointer bits 15 to 8.
// - The pointer low byte sits at its own index next to the high byte to form 16 bits.
// - The pointer low byte is read/write, holds pointer bits 7 to 0, reset value zero.
`timescale 1ns/10ps
`default_nettype none
module interrupt_mask_and_ip_regs (
    // Clock and reset
    input  wire logic                          clk,
    input  wire logic                          reset,
    // AXI4-Lite write address
    input  wire logic [irq_ip_pkg::ADDR_W-1:0] s_axi_awaddr,
    input  wire logic                          s_axi_awvalid,
    output var  logic                          s_axi_awready,
    // AXI4-Lite write data
    input  wire logic [irq_ip_pkg::DATA_W-1:0] s_axi_wdata,
    input  wire logic [3:0]                    s_axi_wstrb,
    input  wire logic                          s_axi_wvalid,
    output var  logic                          s_axi_wready,
    // AXI4-Lite write response
    output var  logic [1:0]                    s_axi_bresp,
    output var  logic                          s_axi_bvalid,
    input  wire logic                          s_axi_bready,
    // AXI4-Lite read address
    input  wire logic [irq_ip_pkg::ADDR_W-1:0] s_axi_araddr,
    input  wire logic                          s_axi_arvalid,
    output var  logic                          s_axi_arready,
    // AXI4-Lite read data
    output var  logic [irq_ip_pkg::DATA_W-1:0] s_axi_rdata,
    output var  logic [1:0]                    s_axi_rresp,
    output var  logic                          s_axi_rvalid,
    input  wire logic                          s_axi_rready,
    // Interrupt levels toward the CPU
    input  wire logic [irq_ip_pkg::LEVELS-1:0] level_request,
    output var  logic [irq_ip_pkg::LEVELS-1:0] recognized_request,
    // Instruction pointer
    output var  logic [15:0]                   instr_ptr
);
    import irq_ip_pkg::*;

    reg_access_if acc ();

    irq_ip_bank u_bank (
        .clk   (clk),
        .reset (reset),
        .acc   (acc)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Write path

    logic              aw_full;
    logic              w_full;
    logic [ADDR_W-1:0] aw_addr;
    logic [7:0]        w_data;
    logic              w_lane0;

    wire aw_take  = s_axi_awvalid && s_axi_awready;
    wire w_take   = s_axi_wvalid && s_axi_wready;
    wire b_done   = s_axi_bvalid && s_axi_bready;
    wire do_write = aw_full && w_full && !s_axi_bvalid;
    wire aw_align = (aw_addr[1:0] == 2'h0);
    wire wr_ok    = aw_align && acc.wr_hit;

    // Only byte lane 0 carries register bits; upper lanes are don't-care
    assign acc.wr_idx  = aw_addr[ADDR_W-1:2];
    assign acc.wr_data = w_data;
    assign acc.wr_en   = do_write && wr_ok && w_lane0;

    always_ff @(posedge clk) begin
        if (reset) begin
            aw_full <= 1'b0;
            aw_addr <= '0;
        end else if (aw_take) begin
            aw_full <= 1'b1;
            aw_addr <= s_axi_awaddr;
        end else if (do_write) begin
            aw_full <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            w_full  <= 1'b0;
            w_data  <= 8'h00;
            w_lane0 <= 1'b0;
        end else if (w_take) begin
            w_full  <= 1'b1;
            w_data  <= s_axi_wdata[7:0];
            w_lane0 <= s_axi_wstrb[0];
        end else if (do_write) begin
            w_full <= 1'b0;
        end
    end

    // Ready stays low from acceptance until the response is taken, so one write at a time
    always_ff @(posedge clk) begin
        if (reset) begin
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
        end else begin
            if (aw_take)     s_axi_awready <= 1'b0;
            else if (b_done) s_axi_awready <= 1'b1;
            if (w_take)      s_axi_wready  <= 1'b0;
            else if (b_done) s_axi_wready  <= 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= RESP_OKAY;
        end else if (do_write) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
        end else if (b_done) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read path

    wire ar_take  = s_axi_arvalid && s_axi_arready;
    wire r_done   = s_axi_rvalid && s_axi_rready;
    wire rd_ok    = (s_axi_araddr[1:0] == 2'h0) && acc.rd_hit;

    assign acc.rd_idx = s_axi_araddr[ADDR_W-1:2];

    always_ff @(posedge clk) begin
        if (reset) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= '0;
            s_axi_rresp   <= RESP_OKAY;
        end else if (ar_take) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= rd_ok ? {24'h000000, acc.rd_data} : '0;
            s_axi_rresp   <= rd_ok ? RESP_OKAY : RESP_SLVERR;
        end else if (r_done) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Toward the CPU

    // A masked level is cut here, so the CPU cannot see it at all
    wire [LEVELS-1:0] next_recognized = level_request & acc.mask;

    always_ff @(posedge clk) begin
        if (reset) begin
            recognized_request <= '0;
            instr_ptr          <= {RST_INSTR_PTR_HIGH, RST_INSTR_PTR_LOW};
        end else begin
            recognized_request <= next_recognized;
            instr_ptr          <= acc.ip;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Assertions

    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    a_mask_write_lands: assert property (
        (acc.wr_en && acc.wr_idx == IDX_IRQ_LEVEL_MASK) |=> ##1
        (recognized_request == ($past(level_request) & $past(w_data, 2)))
    ) else $error("mask write did not gate the levels");

    a_masked_level_quiet: assert property (
        ##1 ((recognized_request & ~$past(acc.mask)) == '0)
    ) else $error("masked level reached the CPU");

    a_unmasked_passes: assert property (
        ##1 (recognized_request == ($past(level_request) & $past(acc.mask)))
    ) else $error("unmasked level not passed");

    a_ip_high_write: assert property (
        (acc.wr_en && acc.wr_idx == IDX_INSTR_PTR_HIGH) |=> ##1
        (instr_ptr[15:IP_HIGH_LSB] == $past(w_data, 2))
    ) else $error("pointer high byte not updated");

    a_ip_low_write: assert property (
        (acc.wr_en && acc.wr_idx == IDX_INSTR_PTR_LOW) |=> ##1
        (instr_ptr[IP_HIGH_LSB-1:IP_LOW_LSB] == $past(w_data, 2))
    ) else $error("pointer low byte not updated");

    a_ip_low_readback: assert property (
        (ar_take && rd_ok && acc.rd_idx == IDX_INSTR_PTR_LOW) |=>
        (s_axi_rvalid && s_axi_rdata[7:0] == instr_ptr[7:0])
    ) else $error("pointer low byte read wrong");

    a_write_answers: assert property (
        do_write |=> s_axi_bvalid && !aw_full && !w_full
    ) else $error("write response missing");

    // A held address must keep the channel closed until the response is out
    a_aw_busy_closed: assert property (
        aw_full |-> !s_axi_awready && !s_axi_bvalid
    ) else $error("write address accepted while busy");

    a_write_slverr: assert property (
        (do_write && !wr_ok) |=> (s_axi_bvalid && s_axi_bresp == RESP_SLVERR)
    ) else $error("refused write not flagged");

    a_read_answers: assert property (
        ar_take |=> (s_axi_rvalid && !s_axi_arready)
    ) else $error("read response missing");

    a_bad_read_zero: assert property (
        (ar_take && !rd_ok) |=> (s_axi_rresp == RESP_SLVERR && s_axi_rdata == '0)
    ) else $error("refused read returned data");

    a_ip_tracks: assert property (
        ##1 (instr_ptr == $past(acc.ip))
    ) else $error("pointer output lags its bytes");

    c_mask_write:  cover property (acc.wr_en && acc.wr_idx == IDX_IRQ_LEVEL_MASK);
    c_ip_pair:     cover property (acc.wr_en && acc.wr_idx == IDX_INSTR_PTR_HIGH
                                   ##[1:20] acc.wr_en && acc.wr_idx == IDX_INSTR_PTR_LOW);
    c_masked_req:  cover property ((level_request & ~acc.mask) != '0);
    c_bad_address: cover property (do_write && !wr_ok);

endmodule : interrupt_mask_and_ip_regs
`default_nettype wire

// ### core/irq_ip_pkg.sv
package irq_ip_pkg;

    localparam int unsigned ADDR_W      = 12;
    localparam int unsigned IDX_W       = 10;
    localparam int unsigned DATA_W      = 32;
    localparam int unsigned REG_W       = 8;
    localparam int unsigned LEVELS      = 8;

    // Register indices; the byte address on the bus is four times the index
    localparam logic [9:0] IDX_INSTR_PTR_HIGH = 10'h0DA;
    localparam logic [9:0] IDX_INSTR_PTR_LOW  = 10'h0DB;
    localparam logic [9:0] IDX_IRQ_LEVEL_MASK = 10'h0DD;

    // Field layout of the pointer halves
    localparam int unsigned IP_HIGH_LSB = 8;
    localparam int unsigned IP_LOW_LSB  = 0;

    // Reset values; the hardware leaves these undefined, zero is chosen
    localparam logic [7:0] RST_INSTR_PTR_HIGH = 8'h00;
    localparam logic [7:0] RST_INSTR_PTR_LOW  = 8'h00;
    localparam logic [7:0] RST_IRQ_LEVEL_MASK = 8'h00;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    function automatic logic is_mapped(input logic [9:0] idx);
        is_mapped = (idx == IDX_INSTR_PTR_HIGH) || (idx == IDX_INSTR_PTR_LOW)
                 || (idx == IDX_IRQ_LEVEL_MASK);
    endfunction : is_mapped

endpackage : irq_ip_pkg

// ### core/reg_access_if.sv
`timescale 1ns/10ps
`default_nettype none
interface reg_access_if;
    logic       wr_en;
    logic [9:0] wr_idx;
    logic [7:0] wr_data;
    logic [9:0] rd_idx;
    logic [7:0] rd_data;
    logic       wr_hit;
    logic       rd_hit;
    logic [7:0] mask;
    logic [15:0] ip;

    modport ctrl (output wr_en, wr_idx, wr_data, rd_idx,
                  input  rd_data, wr_hit, rd_hit, mask, ip);
    modport bank (input  wr_en, wr_idx, wr_data, rd_idx,
                  output rd_data, wr_hit, rd_hit, mask, ip);
endinterface : reg_access_if
`default_nettype wire

// ### core/irq_ip_bank.sv
`timescale 1ns/10ps
`default_nettype none
module irq_ip_bank (
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         reset,
    // Register access
    reg_access_if.bank        acc
);
    import irq_ip_pkg::*;

    logic [7:0] irq_level_mask;
    logic [7:0] instr_ptr_high;
    logic [7:0] instr_ptr_low;

    wire wr_mask = acc.wr_en && (acc.wr_idx == IDX_IRQ_LEVEL_MASK);
    wire wr_high = acc.wr_en && (acc.wr_idx == IDX_INSTR_PTR_HIGH);
    wire wr_low  = acc.wr_en && (acc.wr_idx == IDX_INSTR_PTR_LOW);

    always_ff @(posedge clk) begin
        if (reset) begin
            irq_level_mask <= RST_IRQ_LEVEL_MASK;
            instr_ptr_high <= RST_INSTR_PTR_HIGH;
            instr_ptr_low  <= RST_INSTR_PTR_LOW;
        end else begin
            if (wr_mask) irq_level_mask <= acc.wr_data;
            if (wr_high) instr_ptr_high <= acc.wr_data;
            if (wr_low)  instr_ptr_low  <= acc.wr_data;
        end
    end

    assign acc.wr_hit  = is_mapped(acc.wr_idx);
    assign acc.rd_hit  = is_mapped(acc.rd_idx);
    assign acc.mask    = irq_level_mask;
    assign acc.ip      = {instr_ptr_high, instr_ptr_low};
    assign acc.rd_data = (acc.rd_idx == IDX_IRQ_LEVEL_MASK) ? irq_level_mask :
                         (acc.rd_idx == IDX_INSTR_PTR_HIGH) ? instr_ptr_high :
                         (acc.rd_idx == IDX_INSTR_PTR_LOW)  ? instr_ptr_low  : 8'h00;
endmodule : irq_ip_bank
`default_nettype wire

// ### dv/cpu_side_model.sv
`timescale 1ns/10ps
`default_nettype none
module cpu_side_model (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       reset,
    // Sources and recognition
    input  wire logic [7:0] pattern,
    input  wire logic       clear,
    input  wire logic [7:0] recognized_request,
    output var  logic [7:0] level_request,
    output var  logic [7:0] taken
);
    // Sources go quiet in reset so no stale request meets the mask
    always_ff @(posedge clk) begin
        level_request <= reset ? 8'h00 : pattern;
        taken         <= (reset || clear) ? 8'h00 : (taken | recognized_request);
    end
endmodule : cpu_side_model
`default_nettype wire

// ### dv/interrupt_mask_and_ip_regs_tb.sv
`timescale 1ns/10ps
`default_nettype none
module interrupt_mask_and_ip_regs_tb;
    import irq_ip_pkg::*;
    logic        clk = 1'h0, reset = 1'h1, clear = 1'h0;
    logic [11:0] awaddr = 12'h000, araddr = 12'h000;
    logic [31:0] wdata = 32'h0, rdata;
    logic        awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
    logic        awready, wready, bvalid, arready, rvalid;
    logic [1:0]  bresp, rresp;
    logic [3:0]  wstrb = 4'hF;
    logic [7:0]  pattern = 8'h00, level_request, recognized, taken;
    logic [15:0] instr_ptr;
    int          miscompares = 0, compares = 0;

    always #4 clk = ~clk;

    interrupt_mask_and_ip_regs dut (
        .clk(clk), .reset(reset),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .level_request(level_request), .recognized_request(recognized), .instr_ptr(instr_ptr)
    );
    cpu_side_model cpu (
        .clk(clk), .reset(reset), .pattern(pattern), .clear(clear),
        .recognized_request(recognized), .level_request(level_request), .taken(taken)
    );
    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] ip_of(input logic [7:0] hi, input logic [7:0] lo);
        return {16'h0000, hi, lo};
    endfunction : ip_of
    function automatic logic [31:0] rec_of(input logic [7:0] p, input logic [7:0] m);
        return {24'h000000, p & m};
    endfunction : rec_of
    function automatic logic [11:0] ba(input logic [9:0] idx);
        return {idx, 2'h0};
    endfunction : ba
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic close_out();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : close_out
    // The extra idle edge keeps a following call from driving a strobe twice in one step
    task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] er);
        int n;
        awaddr  <= a;
        wdata   <= {24'h000000, d};
        awvalid <= 1'h1;
        wvalid  <= 1'h1;
        bready  <= 1'h1;
        for (n = 0; n < 40; n++) begin
            @(posedge clk);
            if (awready) awvalid <= 1'h0;
            if (wready) wvalid <= 1'h0;
            if (bvalid) break;
        end
        if (n == 40) begin
            miscompares++;
            close_out();
        end
        chk({30'h0, bresp}, {30'h0, er});
        bready <= 1'h0;
        @(posedge clk);
    endtask : wr
    task automatic rd(input logic [11:0] a, input logic [7:0] d, input logic [1:0] er);
        int n;
        araddr  <= a;
        arvalid <= 1'h1;
        rready  <= 1'h1;
        for (n = 0; n < 40; n++) begin
            @(posedge clk);
            if (arready) arvalid <= 1'h0;
            if (rvalid) break;
        end
        if (n == 40) begin
            miscompares++;
            close_out();
        end
        chk(rdata, {24'h000000, d});
        chk({30'h0, rresp}, {30'h0, er});
        rready <= 1'h0;
        @(posedge clk);
    endtask : rd
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        logic [7:0] hi, lo, m, p;
        int         k;
        k = $urandom(32'h0D77E00D);
        repeat (3) @(posedge clk);
        reset <= 1'h0;
        @(posedge clk);
        rd(ba(IDX_INSTR_PTR_HIGH), RST_INSTR_PTR_HIGH, RESP_OKAY);
        rd(ba(IDX_INSTR_PTR_LOW), RST_INSTR_PTR_LOW, RESP_OKAY);
        rd(ba(IDX_IRQ_LEVEL_MASK), RST_IRQ_LEVEL_MASK, RESP_OKAY);
        for (k = 0; k < 10; k++) begin
            hi = (k == 0) ? 8'hFF : 8'($urandom);
            lo = (k == 0) ? 8'h00 : 8'($urandom);
            wr(ba(IDX_INSTR_PTR_HIGH), hi, RESP_OKAY);
            wr(ba(IDX_INSTR_PTR_LOW), lo, RESP_OKAY);
            rd(ba(IDX_INSTR_PTR_HIGH), hi, RESP_OKAY);
            rd(ba(IDX_INSTR_PTR_LOW), lo, RESP_OKAY);
            chk({16'h0000, instr_ptr}, ip_of(hi, lo));
        end
        // Unaligned and unmapped places must leave the pointer alone
        wr(12'h369, 8'hA5, RESP_SLVERR);
        wr(12'h370, 8'hA5, RESP_SLVERR);
        rd(12'h370, 8'h00, RESP_SLVERR);
        // Lane 0 off: the write is answered but the byte stays as it was
        wstrb <= 4'h0;
        wr(ba(IDX_INSTR_PTR_LOW), ~lo, RESP_OKAY);
        wstrb <= 4'hF;
        rd(ba(IDX_INSTR_PTR_LOW), lo, RESP_OKAY);
        chk({16'h0000, instr_ptr}, ip_of(hi, lo));
        pattern <= 8'hFF;
        for (k = 0; k < 8; k++) begin
            m = 8'h01 << k;
            wr(ba(IDX_IRQ_LEVEL_MASK), m, RESP_OKAY);
            rd(ba(IDX_IRQ_LEVEL_MASK), m, RESP_OKAY);
            chk({24'h000000, recognized}, rec_of(8'hFF, m));
        end
        // First ten patterns run fully masked; the model must record nothing
        for (k = 0; k < 40; k++) begin
            if (k % 10 == 0) begin
                m = (k == 0) ? 8'h00 : 8'($urandom);
                wr(ba(IDX_IRQ_LEVEL_MASK), m, RESP_OKAY);
            end
            p = (k == 1) ? 8'hFF : 8'($urandom);
            pattern <= p;
            clear <= (k == 0);
            repeat (3) @(posedge clk);
            chk({24'h000000, recognized}, rec_of(p, m));
            if (k == 9) chk({24'h000000, taken}, 32'h00000000);
        end
        // A second reset in mid-run must bring every register back
        reset <= 1'h1;
        repeat (3) @(posedge clk);
        reset <= 1'h0;
        @(posedge clk);
        rd(ba(IDX_INSTR_PTR_HIGH), RST_INSTR_PTR_HIGH, RESP_OKAY);
        rd(ba(IDX_IRQ_LEVEL_MASK), RST_IRQ_LEVEL_MASK, RESP_OKAY);
        chk({16'h0000, instr_ptr}, ip_of(RST_INSTR_PTR_HIGH, RST_INSTR_PTR_LOW));
        chk({24'h000000, recognized}, 32'h00000000);
        close_out();
    end
endmodule : interrupt_mask_and_ip_regs_tb
`default_nettype wire
